/* File: rtl/hrcf_pkg.sv */
// Constants and register map for the host run control and flag block.
package hrcf_pkg;
  // ==========================================================
  // Bus geometry
  localparam int AXI_AW = 8;
  localparam int AXI_DW = 32;
  localparam int FLAG_N = 8;
  localparam int FLAG_IW = 3;
  // ==========================================================
  // Register byte offsets
  localparam logic [AXI_AW-1:0] OFS_START = 8'h00;
  localparam logic [AXI_AW-1:0] OFS_RESET = 8'h04;
  localparam logic [AXI_AW-1:0] OFS_STATUS = 8'h08;
  localparam logic [AXI_AW-1:0] OFS_FLAG_CMD = 8'h0c;
  localparam logic [AXI_AW-1:0] OFS_FLAG_READ = 8'h10;
  localparam logic [AXI_AW-1:0] OFS_FLAG_ALL = 8'h14;
  localparam logic [AXI_AW-1:0] OFS_IRQ_STATUS = 8'h18;
  localparam logic [AXI_AW-1:0] OFS_IRQ_MASK = 8'h1c;
  // ==========================================================
  // Field positions
  localparam int RESET_BIT = 0;
  localparam int STATUS_RUN_BIT = 0;
  localparam int FLAG_SET_BIT = 8;
  localparam int FLAG_CLR_BIT = 9;
  localparam int IRQ_HALT_BIT = 0;
  localparam int IRQ_FLAG_BIT = 1;
  localparam int IRQ_N = 2;
  // ==========================================================
  // Reset values and responses
  localparam logic [IRQ_N-1:0] IRQ_MASK_RST = 2'h0;
  localparam logic [FLAG_N-1:0] FLAGS_RST = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

/* File: rtl/hrcf_flag_cell.sv */
// One communication flag bit with host and processor write ports.
module hrcf_flag_cell
  import hrcf_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic host_set,
  input  wire logic host_clr,
  input  wire logic iop_wr,
  input  wire logic iop_val,
  output logic      q
);
  // ==========================================================
  // Host write is checked first so a collision resolves its way.
  wire logic next_q = host_set ? 1'b1 :
                      host_clr ? 1'b0 :
                      iop_wr   ? iop_val : q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= 1'b0;
    end else begin
      q <= next_q;
    end
  end
endmodule

/* File: rtl/hrcf_top.sv */
// Run control, interrupt pending and shared flags behind an AXI4-Lite slave.
module hrcf_top
  import hrcf_pkg::*;
#(
  parameter int PC_W  = 16,
  parameter int INT_N = 8
)(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [AXI_DW-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [AXI_AW-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [AXI_DW-1:0]      s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   irq,
  output logic                   iop_run,
  output logic                   iop_start,
  output logic [PC_W-1:0]        iop_start_addr,
  output logic                   iop_reset,
  output logic                   periph_reset,
  input  wire logic              iop_halt,
  input  wire logic [INT_N-1:0]  iop_int_req,
  input  wire logic [INT_N-1:0]  iop_int_clr,
  output logic [INT_N-1:0]       iop_int_pend,
  input  wire logic              iop_flag_wr,
  input  wire logic [FLAG_IW-1:0] iop_flag_idx,
  input  wire logic              iop_flag_val,
  output logic [FLAG_N-1:0]      iop_flags
);
  // ==========================================================
  // Write channel capture
  logic              aw_got;
  logic              w_got;
  logic [AXI_AW-1:0] awaddr_q;
  logic [AXI_DW-1:0] wdata_q;
  logic [3:0]        wstrb_q;
  logic [IRQ_N-1:0]  irq_status;
  logic [IRQ_N-1:0]  irq_mask;
  logic [FLAG_IW-1:0] flag_sel;

  wire logic aw_hs = s_axi_awvalid & s_axi_awready;
  wire logic w_hs = s_axi_wvalid & s_axi_wready;
  wire logic do_wr = aw_got & w_got & ~s_axi_bvalid;

  wire logic [AXI_DW-1:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire logic [AXI_DW-1:0] wd = wdata_q & wmask;

  wire logic wr_start = do_wr && (awaddr_q == OFS_START);
  wire logic wr_reset = do_wr && (awaddr_q == OFS_RESET);
  wire logic wr_fcmd = do_wr && (awaddr_q == OFS_FLAG_CMD);
  wire logic wr_fsel = do_wr && (awaddr_q == OFS_FLAG_READ);
  wire logic wr_mask = do_wr && (awaddr_q == OFS_IRQ_MASK);
  wire logic wr_hit = wr_start | wr_reset | wr_fcmd | wr_fsel | wr_mask;

  // Writes to read-only offsets still answer OKAY; only holes decode-error.
  wire logic wr_mapped = wr_hit || (awaddr_q == OFS_STATUS) || (awaddr_q == OFS_FLAG_ALL) ||
                         (awaddr_q == OFS_IRQ_STATUS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      awaddr_q <= '0;
      s_axi_awready <= 1'b1;
    end else if (aw_hs) begin
      aw_got <= 1'b1;
      awaddr_q <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (do_wr) begin
      aw_got <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= 4'h0;
      s_axi_wready <= 1'b1;
    end else if (w_hs) begin
      w_got <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (do_wr) begin
      w_got <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Run control
  wire logic start_cmd = wr_start && (wstrb_q != 4'h0);
  wire logic reset_cmd = wr_reset && wd[RESET_BIT];
  wire logic next_run = reset_cmd ? 1'b0 :
                        start_cmd ? 1'b1 :
                        iop_halt  ? 1'b0 : iop_run;
  wire logic halt_evt = iop_run & ~next_run;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      iop_run <= 1'b0;
      iop_start <= 1'b0;
      iop_start_addr <= '0;
      iop_reset <= 1'b0;
      periph_reset <= 1'b0;
    end else begin
      iop_run <= next_run;
      iop_start <= start_cmd & ~reset_cmd;
      if (start_cmd) begin
        iop_start_addr <= wd[PC_W-1:0];
      end
      iop_reset <= reset_cmd;
      periph_reset <= reset_cmd;
    end
  end

  // ==========================================================
  // Processor interrupt pending: a new request beats a core clear,
  // but the host reset command wipes everything.
  always_ff @(posedge aclk) begin
    if (!aresetn || reset_cmd) begin
      iop_int_pend <= '0;
    end else begin
      iop_int_pend <= (iop_int_pend & ~iop_int_clr) | iop_int_req;
    end
  end

  // ==========================================================
  // Communication flags
  wire logic host_set_cmd = wr_fcmd && wd[FLAG_SET_BIT];
  wire logic host_clr_cmd = wr_fcmd && wd[FLAG_CLR_BIT] && !wd[FLAG_SET_BIT];
  wire logic [FLAG_IW-1:0] host_idx = wd[FLAG_IW-1:0];

  genvar gi;
  generate
    for (gi = 0; gi < FLAG_N; gi++) begin : g_flag
      hrcf_flag_cell u_cell (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .host_set (host_set_cmd && (host_idx == FLAG_IW'(gi))),
        .host_clr (host_clr_cmd && (host_idx == FLAG_IW'(gi))),
        .iop_wr   (iop_flag_wr && (iop_flag_idx == FLAG_IW'(gi))),
        .iop_val  (iop_flag_val),
        .q        (iop_flags[gi])
      );
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_sel <= '0;
    end else if (wr_fsel) begin
      flag_sel <= wd[FLAG_IW-1:0];
    end
  end

  // ==========================================================
  // Host interrupts: halt and processor flag write events.
  wire logic ar_hs = s_axi_arvalid & s_axi_arready;
  wire logic rd_irq = ar_hs && (s_axi_araddr == OFS_IRQ_STATUS);
  wire logic [IRQ_N-1:0] irq_evt = {iop_flag_wr, halt_evt};
  // Set wins over the read clear so an event in the read cycle survives.
  wire logic [IRQ_N-1:0] next_irq_status = (rd_irq ? '0 : irq_status) | irq_evt;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= '0;
      irq_mask <= IRQ_MASK_RST;
      irq <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      if (wr_mask) begin
        irq_mask <= wd[IRQ_N-1:0];
      end
      irq <= |(next_irq_status & (wr_mask ? wd[IRQ_N-1:0] : irq_mask));
    end
  end

  // ==========================================================
  // Read channel
  wire logic [AXI_DW-1:0] rd_status = {{(AXI_DW-1){1'b0}}, iop_run};
  wire logic [AXI_DW-1:0] rd_flag = {{(AXI_DW-1){1'b0}}, iop_flags[flag_sel]};
  wire logic [AXI_DW-1:0] rd_all = {{(AXI_DW-FLAG_N){1'b0}}, iop_flags};
  wire logic [AXI_DW-1:0] rd_irqs = {{(AXI_DW-IRQ_N){1'b0}}, irq_status};
  wire logic [AXI_DW-1:0] rd_mask = {{(AXI_DW-IRQ_N){1'b0}}, irq_mask};
  wire logic [AXI_DW-1:0] rd_start = {{(AXI_DW-PC_W){1'b0}}, iop_start_addr};

  wire logic rd_hit = (s_axi_araddr == OFS_START) || (s_axi_araddr == OFS_RESET) ||
                      (s_axi_araddr == OFS_STATUS) || (s_axi_araddr == OFS_FLAG_CMD) ||
                      (s_axi_araddr == OFS_FLAG_READ) || (s_axi_araddr == OFS_FLAG_ALL) ||
                      (s_axi_araddr == OFS_IRQ_STATUS) || (s_axi_araddr == OFS_IRQ_MASK);

  wire logic [AXI_DW-1:0] rd_mux =
    (s_axi_araddr == OFS_START)      ? rd_start :
    (s_axi_araddr == OFS_STATUS)     ? rd_status :
    (s_axi_araddr == OFS_FLAG_READ)  ? rd_flag :
    (s_axi_araddr == OFS_FLAG_ALL)   ? rd_all :
    (s_axi_araddr == OFS_IRQ_STATUS) ? rd_irqs :
    (s_axi_araddr == OFS_IRQ_MASK)   ? rd_mask : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (ar_hs) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule

/* File: test/hrcf_sva.sv */
// Port checks for the run control and flag block.
module hrcf_sva
  import hrcf_pkg::*;
#(
  parameter int INT_N = 8
)(
  input wire logic               aclk,
  input wire logic               aresetn,
  input wire logic               s_axi_bvalid,
  input wire logic               iop_run,
  input wire logic               iop_start,
  input wire logic               iop_reset,
  input wire logic               periph_reset,
  input wire logic               iop_halt,
  input wire logic [INT_N-1:0]   iop_int_pend,
  input wire logic               iop_flag_wr,
  input wire logic [FLAG_IW-1:0] iop_flag_idx,
  input wire logic               iop_flag_val,
  input wire logic [FLAG_N-1:0]  iop_flags
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ====================
  // Checks
  a_start_runs: assert property (iop_start |-> ##[0:1] iop_run)
    else $error("start left processor stopped");
  a_start_pulse: assert property (iop_start |=> !iop_start)
    else $error("start pulse too long");
  a_reset_halts: assert property (iop_reset |-> ##[0:1] !iop_run)
    else $error("reset left processor running");
  a_reset_clears: assert property (iop_reset |-> ##[0:1] iop_int_pend == '0)
    else $error("reset left interrupts pending");
  a_reset_pair: assert property (iop_reset |-> periph_reset ##1 !periph_reset)
    else $error("peripheral reset missing");
  a_halt_stops: assert property (iop_halt && iop_run && !iop_start |=> !iop_run || iop_start)
    else $error("halt ignored");
  a_iop_flag: assert property (iop_flag_wr ##1 !$rose(s_axi_bvalid) |->
    iop_flags[$past(iop_flag_idx)] == $past(iop_flag_val))
    else $error("processor flag write lost");
  a_flags_hold: assert property (!$past(iop_flag_wr) && !$rose(s_axi_bvalid) |-> $stable(iop_flags))
    else $error("flags changed without a write");
endmodule

bind hrcf_top hrcf_sva #(.INT_N(INT_N)) hrcf_sva_i (.aclk, .aresetn, .s_axi_bvalid, .iop_run, .iop_start,
  .iop_reset, .periph_reset, .iop_halt, .iop_int_pend, .iop_flag_wr, .iop_flag_idx, .iop_flag_val, .iop_flags);

/* File: test/hrcf_core_model.sv */
// Processor core stand-in: runs a fixed time after start, then halts.
module hrcf_core_model
  import hrcf_pkg::*;
#(
  parameter int RUN_CYC = 20
)(
  input wire logic  aclk,
  input wire logic  iop_start,
  input wire logic  iop_reset,
  output logic      iop_halt = 0,
  output logic[7:0] iop_int_req = '0
);
  int cnt = 0;
  // ====================
  // Run timer
  always @(posedge aclk) begin
    iop_halt <= (cnt == 1);
    iop_int_req <= {7'h00, iop_start};
    if (iop_start) cnt <= RUN_CYC;
    else if (iop_reset) cnt <= 0;
    else if (cnt > 0) cnt <= cnt - 1;
  end
endmodule

/* File: test/hrcf_top_bench.sv */
// Self-checking bench for the run control and flag block.
module hrcf_top_bench
  import hrcf_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        aclk = 0, aresetn = 0, pw = 0, iop_flag_val = 0;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0, iop_int_req, iop_int_pend, iop_flags;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd_d;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic        iop_run, iop_start, iop_reset, periph_reset, iop_halt, iop_flag_wr;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rd_r, wr_r;
  logic [15:0] iop_start_addr;
  logic [2:0]  iop_flag_idx = '0;
  int          mismatches = 0, check_count = 0;
  // The processor write drops once the host write lands, so the clash edge is exact.
  assign iop_flag_wr = pw & ~s_axi_bvalid;
  always #2.5 aclk = ~aclk;
  hrcf_top hrcf_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .irq, .iop_run, .iop_start, .iop_start_addr, .iop_reset, .periph_reset, .iop_halt, .iop_int_req,
    .iop_int_clr(8'h00), .iop_int_pend, .iop_flag_wr, .iop_flag_idx, .iop_flag_val, .iop_flags);
  hrcf_core_model hrcf_core_model_i (.aclk, .iop_start, .iop_reset, .iop_halt, .iop_int_req);
  // ====================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_wdata <= d;
    s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 0;
    wr_r = s_axi_bresp;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    rd(a, rd_d, rd_r);
    chk(32'(rd_r), 32'(RESP_OKAY));
    chk(rd_d, exp);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ====================
  // Tests
  initial begin
    repeat (5000) @(posedge aclk);
    mismatches++;
    close_out;
  end
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rc(OFS_STATUS, 32'h0000_0000);
    rc(OFS_FLAG_ALL, 32'h0000_0000);
    rc(OFS_IRQ_MASK, 32'h0000_0000);
    rd(8'h20, rd_d, rd_r);
    chk(32'(rd_r), 32'(RESP_DECERR));
    wr(8'h20, 32'h0000_0001);
    chk(32'(wr_r), 32'(RESP_DECERR));
    wr(OFS_STATUS, 32'h0000_0001);
    chk(32'(wr_r), 32'(RESP_OKAY));
    rc(OFS_STATUS, 32'h0000_0000);
    $display("test reset done");
    // The start write also loads its data as the start address, so iop_start_addr is checked.
    wr(OFS_START, 32'h0000_0a5c);
    chk(32'(wr_r), 32'(RESP_OKAY));
    #1 chk(32'(iop_start_addr), 32'h0000_0a5c);
    rc(OFS_START, 32'h0000_0a5c);
    rc(OFS_STATUS, 32'h0000_0001);
    repeat (30) @(posedge aclk);
    rc(OFS_STATUS, 32'h0000_0000);
    #1 chk(32'(irq), 32'h0000_0000);
    wr(OFS_IRQ_MASK, 32'h0000_0001);
    #1 chk(32'(irq), 32'h0000_0001);
    rc(OFS_IRQ_STATUS, 32'h0000_0001);
    @(posedge aclk);
    #1 chk(32'(irq), 32'h0000_0000);
    $display("test start done");
    wr(OFS_START, 32'h0000_0100);
    repeat (3) @(posedge aclk);
    #1 chk(32'(iop_int_pend), 32'h0000_0001);
    wr(OFS_RESET, 32'h0000_0001);
    #1 chk(32'(iop_int_pend), 32'h0000_0000);
    chk(32'(iop_run), 32'h0000_0000);
    chk(32'(irq), 32'h0000_0001);
    rc(OFS_STATUS, 32'h0000_0000);
    $display("test halt done");
    for (int i = 0; i < 8; i++) begin
      wr(OFS_FLAG_CMD, 32'h0000_0100 | i);
      rc(OFS_FLAG_ALL, (32'h0000_0002 << i) - 32'h0000_0001);
      wr(OFS_FLAG_READ, i);
      rc(OFS_FLAG_READ, 32'h0000_0001);
    end
    wr(OFS_FLAG_CMD, 32'h0000_0203);
    rc(OFS_FLAG_ALL, 32'h0000_00f7);
    wr(OFS_FLAG_READ, 32'h0000_0003);
    rc(OFS_FLAG_READ, 32'h0000_0000);
    iop_flag_idx <= 3'h5;
    pw <= 1'b1;
    @(posedge aclk);
    pw <= 1'b0;
    rc(OFS_FLAG_ALL, 32'h0000_00d7);
    iop_flag_idx <= 3'h1;
    iop_flag_val <= 1'b1;
    pw <= 1'b1;
    wr(OFS_FLAG_CMD, 32'h0000_0201);
    pw <= 1'b0;
    rc(OFS_FLAG_ALL, 32'h0000_00d5);
    wr(OFS_FLAG_READ, 32'h0000_0005);
    rc(OFS_FLAG_READ, 32'h0000_0000);
    wr(OFS_FLAG_READ, 32'h0000_0007);
    rc(OFS_FLAG_READ, 32'h0000_0001);
    rc(OFS_IRQ_STATUS, 32'h0000_0003);
    $display("test flags done");
    close_out;
  end
endmodule
